// [hdl/rbr_ctrl.sv]
// ram back-up entry, retention, reinitialisation and wakeup control
module rbr_ctrl
  import rbr_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // decoded instruction stream, one pulse per executed instruction
  input wire logic i_instr_valid,
  input wire logic i_power_off_enable_instr,
  input wire logic i_power_off_instr,
  input wire logic i_watchdog_restart_instr,
  input wire logic i_voltage_drop_enable_instr,
  input wire logic i_has_voltage_drop,
  // external wakeup, already qualified per pin
  input wire logic i_ext_wakeup,
  // configuration register writes
  input wire logic i_cfg_we,
  input wire logic [3:0] i_cfg_sel,
  input wire logic [rbr_pkg::REG_W-1:0] i_cfg_wdata,
  // port output latch
  input wire logic i_port_we,
  input wire logic [rbr_pkg::REG_W-1:0] i_port_wdata,
  // flag events and clears
  input wire logic i_ext_irq_set,
  input wire logic i_ext_irq_clr,
  input wire logic i_timer_a_set,
  input wire logic i_timer_a_clr,
  input wire logic i_timer_b_set,
  input wire logic i_timer_b_clr,
  input wire logic i_conv_done_set,
  input wire logic i_conv_done_clr,
  input wire logic i_serial_done_set,
  input wire logic i_serial_done_clr,
  input wire logic i_irq_enable_set,
  input wire logic i_irq_enable_clr,
  input wire logic i_wdog_first_set,
  input wire logic i_wdog_second_set,
  input wire logic i_wdog_second_clr,
  input wire logic i_power_down_clr,
  // stack pointer update from the core
  input wire logic i_sp_we,
  input wire logic [2:0] i_sp_wdata,
  // state
  output rbr_pkg::rbr_state_t o_state,
  output logic o_in_backup,
  output logic o_osc_stop,
  output logic o_restart,
  output logic [5:0] o_restart_page,
  output logic [11:0] o_restart_addr,
  output logic o_power_down_flag,
  // function reinitialisation strobes
  output logic o_serial_func_init,
  output logic o_conv_func_init,
  // retained registers
  output logic [rbr_pkg::REG_W-1:0] o_serial_ctrl_reg,
  output logic [rbr_pkg::REG_W-1:0] o_converter_ctrl_reg,
  output logic [rbr_pkg::REG_W-1:0] o_wake_cfg_port_a,
  output logic [rbr_pkg::REG_W-1:0] o_wake_cfg_port_b,
  output logic [rbr_pkg::REG_W-1:0] o_wake_cfg_port_c,
  output logic [rbr_pkg::REG_W-1:0] o_wake_condition_cfg,
  output logic [rbr_pkg::REG_W-1:0] o_pullup_cfg_a,
  output logic [rbr_pkg::REG_W-1:0] o_pullup_cfg_b,
  output logic [rbr_pkg::REG_W-1:0] o_pullup_cfg_c,
  output logic [rbr_pkg::REG_W-1:0] o_drive_structure_a,
  output logic [rbr_pkg::REG_W-1:0] o_drive_structure_d,
  output logic [rbr_pkg::REG_W-1:0] o_extra_structure_cfg,
  output logic [rbr_pkg::REG_W-1:0] o_port_level,
  // flags
  output logic o_ext_irq_request_flag,
  output logic o_timer_a_irq_flag,
  output logic o_timer_b_irq_flag,
  output logic o_conversion_done_flag,
  output logic o_serial_done_flag,
  output logic o_global_irq_enable,
  output logic o_watchdog_flag_first,
  output logic o_watchdog_flag_second,
  output logic o_watchdog_enable_flag,
  output logic [2:0] o_stack_level_pointer,
  output logic o_voltage_drop_active
);
  import rbr_pkg::*;

  rbr_state_t state_r;
  rbr_state_t state_nxt;
  logic enter_backup;
  logic backup_init;
  logic power_down_r;
  logic restart_r;
  logic vdrop_en_r;
  logic [2:0] sp_r;
  logic [REG_W-1:0] port_r;
  logic [REG_W-1:0] cfg_q [NUM_CFG];

  // power-off only counts when the previous executed instruction was the enable
  assign enter_backup = i_instr_valid && i_power_off_instr
                        && (state_r == RBR_ARMED);
  // one-cycle strobe on the entry edge; clock stops after, so init is done here
  assign backup_init = enter_backup;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RBR_RUN: begin
        if (i_instr_valid && i_power_off_enable_instr) begin
          state_nxt = RBR_ARMED;
        end
      end
      RBR_ARMED: begin
        if (enter_backup) begin
          state_nxt = RBR_BACKUP;
        end else if (i_instr_valid && !i_power_off_enable_instr) begin
          state_nxt = RBR_RUN;
        end
      end
      RBR_BACKUP: begin
        // oscillator is stopped: nothing but a wakeup pin leaves here
        if (i_ext_wakeup) begin
          state_nxt = RBR_WAKE;
        end
      end
      RBR_WAKE: begin
        state_nxt = RBR_RUN;
      end
      default: begin
        state_nxt = RBR_RUN;
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_r <= RBR_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  // warm start marker and restart pulse; cold reset leaves the flag at zero
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      power_down_r <= 1'b0;
    end else if (enter_backup) begin
      power_down_r <= 1'b1;
    end else if (i_power_down_clr && state_r == RBR_RUN) begin
      power_down_r <= 1'b0;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      restart_r <= 1'b0;
    end else begin
      restart_r <= (state_r == RBR_BACKUP) && i_ext_wakeup;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sp_r <= SP_RST;
    end else if (backup_init) begin
      sp_r <= SP_BACKUP;
    end else if (i_sp_we) begin
      sp_r <= i_sp_wdata;
    end
  end

  // detector enable survives into back-up; only a cold reset clears it
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      vdrop_en_r <= 1'b0;
    end else if (i_instr_valid && i_voltage_drop_enable_instr && i_has_voltage_drop) begin
      vdrop_en_r <= 1'b1;
    end
  end

  // port levels are never touched by entry or wakeup
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      port_r <= REG_RST;
    end else if (i_port_we) begin
      port_r <= i_port_wdata;
    end
  end

  // retained bank: back-up never writes these, so they keep their contents
  genvar gi;
  generate
    for (gi = 0; gi < NUM_CFG; gi++) begin : g_cfg
      rbr_hold_reg u_reg (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_we(i_cfg_we && i_cfg_sel == 4'(gi) && i_cfg_sel <= CFG_IX_MAX),
        .i_wdata(i_cfg_wdata),
        .o_q(cfg_q[gi])
      );
    end
  endgenerate

  // flags cleared to initial value at back-up entry
  rbr_flag u_ext_irq (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_set(i_ext_irq_set),
    .i_clr(i_ext_irq_clr), .i_init(backup_init), .o_q(o_ext_irq_request_flag)
  );
  rbr_flag u_conv_done (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_set(i_conv_done_set),
    .i_clr(i_conv_done_clr), .i_init(backup_init), .o_q(o_conversion_done_flag)
  );
  rbr_flag u_serial_done (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_set(i_serial_done_set),
    .i_clr(i_serial_done_clr), .i_init(backup_init), .o_q(o_serial_done_flag)
  );
  rbr_flag u_irq_en (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_set(i_irq_enable_set),
    .i_clr(i_irq_enable_clr), .i_init(backup_init), .o_q(o_global_irq_enable)
  );
  // first watchdog flag is cleared by restart, and by back-up
  rbr_flag u_wdog_first (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_set(i_wdog_first_set),
    .i_clr(i_instr_valid && i_watchdog_restart_instr), .i_init(backup_init),
    .o_q(o_watchdog_flag_first)
  );
  rbr_flag u_wdog_second (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_set(i_wdog_second_set),
    .i_clr(i_wdog_second_clr), .i_init(backup_init), .o_q(o_watchdog_flag_second)
  );
  // timer flags are not reinitialised; their value after back-up is not defined
  rbr_flag u_timer_a (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_set(i_timer_a_set),
    .i_clr(i_timer_a_clr), .i_init(1'b0), .o_q(o_timer_a_irq_flag)
  );
  rbr_flag u_timer_b (
    .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_set(i_timer_b_set),
    .i_clr(i_timer_b_clr), .i_init(1'b0), .o_q(o_timer_b_irq_flag)
  );

  // watchdog enable is not a listed flag; cold reset and back-up entry both set it, nothing clears it
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_watchdog_enable_flag <= 1'b1;
    end else if (backup_init) begin
      o_watchdog_enable_flag <= 1'b1;
    end
  end

  // registered copies of the function init strobes
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_serial_func_init <= 1'b0;
      o_conv_func_init <= 1'b0;
    end else begin
      o_serial_func_init <= backup_init;
      o_conv_func_init <= backup_init;
    end
  end

  assign o_state = state_r;
  assign o_in_backup = (state_r == RBR_BACKUP);
  assign o_osc_stop = (state_r == RBR_BACKUP);
  assign o_restart = restart_r;
  assign o_restart_page = START_PAGE;
  assign o_restart_addr = START_ADDR;
  assign o_power_down_flag = power_down_r;
  assign o_stack_level_pointer = sp_r;
  assign o_voltage_drop_active = i_has_voltage_drop
                                 && (state_r != RBR_BACKUP || vdrop_en_r);
  assign o_port_level = port_r;
  assign o_serial_ctrl_reg = cfg_q[IX_SERIAL_CTRL];
  assign o_converter_ctrl_reg = cfg_q[IX_CONV_CTRL];
  assign o_wake_cfg_port_a = cfg_q[IX_WAKE_A];
  assign o_wake_cfg_port_b = cfg_q[IX_WAKE_B];
  assign o_wake_cfg_port_c = cfg_q[IX_WAKE_C];
  assign o_wake_condition_cfg = cfg_q[IX_WAKE_COND];
  assign o_pullup_cfg_a = cfg_q[IX_PULLUP_A];
  assign o_pullup_cfg_b = cfg_q[IX_PULLUP_B];
  assign o_pullup_cfg_c = cfg_q[IX_PULLUP_C];
  assign o_drive_structure_a = cfg_q[IX_DRIVE_A];
  assign o_drive_structure_d = cfg_q[IX_DRIVE_D];
  assign o_extra_structure_cfg = cfg_q[IX_EXTRA];
endmodule : rbr_ctrl

// [hdl/rbr_flag.sv]
// one hardware-set, software-cleared flag that back-up returns to its initial value
module rbr_flag (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // control
  input wire logic i_set,
  input wire logic i_clr,
  input wire logic i_init,
  // value
  output logic o_q
);
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_q <= 1'b0;
    end else if (i_init) begin
      o_q <= 1'b0;
    end else if (i_set) begin
      // an event in the clearing cycle wins
      o_q <= 1'b1;
    end else if (i_clr) begin
      o_q <= 1'b0;
    end
  end
endmodule : rbr_flag

// [hdl/rbr_hold_reg.sv]
// one register that is kept across back-up, reset only by a cold reset
module rbr_hold_reg
  import rbr_pkg::*;
(
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // write port
  input wire logic i_we,
  input wire logic [REG_W-1:0] i_wdata,
  // value
  output logic [REG_W-1:0] o_q
);
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_q <= REG_RST;
    end else if (i_we) begin
      o_q <= i_wdata;
    end
  end
endmodule : rbr_hold_reg

// [hdl/rbr_pkg.sv]
// constants and types for the ram back-up retention controller
package rbr_pkg;
  localparam int unsigned REG_W = 4;
  localparam logic [3:0] REG_RST = 4'h0;
  localparam logic [2:0] SP_BACKUP = 3'h7;
  localparam logic [2:0] SP_RST = 3'h7;
  localparam logic [11:0] START_ADDR = 12'h000;
  localparam logic [5:0] START_PAGE = 6'h00;
  localparam int unsigned NUM_CFG = 12;
  // index of each retained configuration register in the cfg bank
  localparam int unsigned IX_SERIAL_CTRL = 0;
  localparam int unsigned IX_CONV_CTRL = 1;
  localparam int unsigned IX_WAKE_A = 2;
  localparam int unsigned IX_WAKE_B = 3;
  localparam int unsigned IX_WAKE_C = 4;
  localparam int unsigned IX_WAKE_COND = 5;
  localparam int unsigned IX_PULLUP_A = 6;
  localparam int unsigned IX_PULLUP_B = 7;
  localparam int unsigned IX_PULLUP_C = 8;
  localparam int unsigned IX_DRIVE_A = 9;
  localparam int unsigned IX_DRIVE_D = 10;
  localparam int unsigned IX_EXTRA = 11;
  localparam logic [3:0] CFG_IX_MAX = 4'hb;
  typedef enum logic [1:0] {
    RBR_RUN = 2'b00,
    RBR_ARMED = 2'b01,
    RBR_BACKUP = 2'b10,
    RBR_WAKE = 2'b11
  } rbr_state_t;
endpackage : rbr_pkg

// [test/rbr_ctrl_asserts.sv]
// port-level assertions for the back-up controller
module rbr_ctrl_asserts
  import rbr_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_instr_valid,
  input wire logic i_power_off_enable_instr,
  input wire logic i_power_off_instr,
  input wire logic i_has_voltage_drop,
  input wire logic i_ext_wakeup,
  input wire logic i_cfg_we,
  input wire logic i_port_we,
  input wire logic [1:0] o_state,
  input wire logic o_in_backup,
  input wire logic o_restart,
  input wire logic o_power_down_flag,
  input wire logic o_serial_func_init,
  input wire logic o_conv_func_init,
  input wire logic [rbr_pkg::REG_W-1:0] o_serial_ctrl_reg,
  input wire logic [rbr_pkg::REG_W-1:0] o_port_level,
  input wire logic o_ext_irq_request_flag,
  input wire logic o_conversion_done_flag,
  input wire logic o_serial_done_flag,
  input wire logic o_global_irq_enable,
  input wire logic o_watchdog_flag_first,
  input wire logic o_watchdog_flag_second,
  input wire logic [2:0] o_stack_level_pointer,
  input wire logic o_voltage_drop_active
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence s_enter;
    o_state == RBR_ARMED && i_instr_valid && i_power_off_instr;
  endsequence
  sequence s_wake;
    o_restart && o_state == RBR_WAKE ##1 o_state == RBR_RUN;
  endsequence
  a_poweroff_noop: assert property (
    o_state == RBR_RUN && i_instr_valid && i_power_off_instr && !i_power_off_enable_instr
    |=> o_state == RBR_RUN) else $error("power-off left run state");
  a_backup_entry: assert property (
    s_enter |=> o_in_backup && o_power_down_flag && o_stack_level_pointer == SP_BACKUP)
    else $error("back-up entry wrong");
  a_flags_init: assert property (
    s_enter |=> !(o_ext_irq_request_flag | o_conversion_done_flag | o_serial_done_flag
    | o_global_irq_enable)) else $error("flag not initialised");
  a_wdog_init: assert property (
    s_enter |=> !o_watchdog_flag_first && !o_watchdog_flag_second)
    else $error("watchdog flag not initialised");
  a_func_reinit: assert property (
    s_enter |=> o_serial_func_init && o_conv_func_init) else $error("no reinit");
  a_regs_kept: assert property (
    s_enter ##0 (!i_cfg_we && !i_port_we)
    |=> ($stable(o_serial_ctrl_reg) && $stable(o_port_level)) [*2])
    else $error("kept register changed");
  a_backup_stays: assert property (
    o_in_backup && !i_ext_wakeup |=> o_in_backup) else $error("left back-up unwoken");
  a_wake_restart: assert property (
    o_in_backup && i_ext_wakeup |=> s_wake) else $error("wakeup restart wrong");
  a_vdrop_strap: assert property (
    !i_has_voltage_drop |-> !o_voltage_drop_active) else $error("detector without strap");
endmodule : rbr_ctrl_asserts

bind rbr_ctrl rbr_ctrl_asserts rbr_ctrl_asserts_inst (.*);

// [test/rbr_wake_src.sv]
// external wakeup pin model: one qualified wakeup level after a delay
module rbr_wake_src (
  // clock
  input wire logic i_ref_clk,
  // request from the bench
  input wire logic i_go,
  input wire logic [7:0] i_delay,
  // qualified wakeup
  output logic o_wakeup
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = -1;
  logic go;
  logic fire;
  initial o_wakeup = 1'b0;
  // the oscillator is stopped in back-up, so only this level can end it
  always @(posedge i_ref_clk) begin
    go = i_go;
    #10;
    fire = !go && cnt == 0;
    if (go) cnt = i_delay;
    else if (cnt >= 0) cnt = cnt - 1;
    // one write per edge, so the pin never glitches within a time step
    o_wakeup = fire;
  end
endmodule : rbr_wake_src

// [test/test_rbr_ctrl.sv]
// self-checking bench for the back-up retention controller
module test_rbr_ctrl;
  timeunit 1ns;
  timeprecision 1ns;
  import rbr_pkg::*;
  logic i_ref_clk, i_nrst = 0, i_instr_valid = 0, i_has_voltage_drop = 1, go = 0;
  logic i_power_off_enable_instr, i_power_off_instr, i_watchdog_restart_instr;
  logic i_voltage_drop_enable_instr, i_ext_wakeup, i_cfg_we = 0, i_port_we = 0;
  logic i_ext_irq_set, i_ext_irq_clr, i_timer_a_set, i_timer_a_clr, i_timer_b_set;
  logic i_timer_b_clr, i_conv_done_set, i_conv_done_clr, i_serial_done_set;
  logic i_serial_done_clr, i_irq_enable_set, i_irq_enable_clr, i_wdog_first_set;
  logic i_wdog_second_set, i_wdog_second_clr, i_power_down_clr, i_sp_we = 0;
  logic [3:0] i_cfg_sel = 0, i_cfg_wdata = 0, i_port_wdata = 0, exp_r [14];
  logic [2:0] i_sp_wdata = 0, o_stack_level_pointer;
  logic [7:0] lf, dly = 0;
  rbr_state_t o_state;
  logic o_in_backup, o_osc_stop, o_restart, o_power_down_flag, o_serial_func_init;
  logic o_conv_func_init, o_ext_irq_request_flag, o_timer_a_irq_flag, o_timer_b_irq_flag;
  logic o_conversion_done_flag, o_serial_done_flag, o_global_irq_enable;
  logic o_watchdog_flag_first, o_watchdog_flag_second, o_watchdog_enable_flag;
  logic o_voltage_drop_active;
  logic [5:0] o_restart_page;
  logic [11:0] o_restart_addr;
  logic [3:0] o_serial_ctrl_reg, o_converter_ctrl_reg, o_wake_cfg_port_a, o_wake_cfg_port_b;
  logic [3:0] o_wake_cfg_port_c, o_wake_condition_cfg, o_pullup_cfg_a, o_pullup_cfg_b;
  logic [3:0] o_pullup_cfg_c, o_drive_structure_a, o_drive_structure_d;
  logic [3:0] o_extra_structure_cfg, o_port_level;
  int failures = 0, checked = 0, cyc = 0;
  wire [51:0] regs = {o_port_level, o_extra_structure_cfg, o_drive_structure_d,
    o_drive_structure_a, o_pullup_cfg_c, o_pullup_cfg_b, o_pullup_cfg_a, o_wake_condition_cfg,
    o_wake_cfg_port_c, o_wake_cfg_port_b, o_wake_cfg_port_a, o_converter_ctrl_reg,
    o_serial_ctrl_reg};
  wire [5:0] fl = {o_ext_irq_request_flag, o_conversion_done_flag, o_serial_done_flag,
    o_global_irq_enable, o_watchdog_flag_first, o_watchdog_flag_second};
  rbr_ctrl rbr_ctrl_inst (.*);
  rbr_wake_src rbr_wake_src_inst (.i_ref_clk(i_ref_clk), .i_go(go), .i_delay(dly),
    .o_wakeup(i_ext_wakeup));
  initial begin
    i_ref_clk = 0;
    forever #50 i_ref_clk = ~i_ref_clk;
  end
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : lfsr
  task automatic check(input string n, input logic [17:0] s, input logic [17:0] e);
    checked++;
    if (s !== e) begin
      failures++;
      $display("FAIL %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic step();
    @(posedge i_ref_clk);
    #10;
  endtask : step
  task automatic instr(input int k);
    {i_voltage_drop_enable_instr, i_watchdog_restart_instr, i_power_off_instr,
      i_power_off_enable_instr} = 4'h1 << k;
    i_instr_valid = 1;
    step();
  endtask : instr
  // set order: ext conv serial irqen wdog1 wdog2 timer_a timer_b
  task automatic flags(input logic [7:0] s, input logic [7:0] c);
    {i_ext_irq_set, i_conv_done_set, i_serial_done_set, i_irq_enable_set, i_wdog_first_set,
      i_wdog_second_set, i_timer_a_set, i_timer_b_set} = s;
    {i_ext_irq_clr, i_conv_done_clr, i_serial_done_clr, i_irq_enable_clr, i_wdog_second_clr,
      i_timer_a_clr, i_timer_b_clr, i_power_down_clr} = c;
    step();
  endtask : flags
  task automatic kept();
    for (int i = 0; i < 13; i++) check("kept reg", regs[i*4+:4], exp_r[i]);
  endtask : kept
  task automatic round(input logic sv, input logic [7:0] d);
    flags(8'hff, 8'h00);
    i_sp_we = 1;
    i_sp_wdata = {1'b0, d[1:0]};
    flags(8'h00, 8'h00);
    i_sp_we = 0;
    check("sp wr", o_stack_level_pointer, {1'b0, d[1:0]});
    if (sv) instr(3);
    instr(2);
    instr(0);
    instr(1);
    i_instr_valid = 0;
    check("state", o_state, RBR_BACKUP);
    check("osc stop", o_osc_stop, 1);
    check("pd flag", o_power_down_flag, 1);
    check("sp", o_stack_level_pointer, SP_BACKUP);
    check("flags", fl, 0);
    check("vdrop", o_voltage_drop_active, sv);
    check("init", {o_serial_func_init, o_conv_func_init}, 2'b11);
    dly = d;
    go = 1;
    step();
    go = 0;
    check("init end", {o_serial_func_init, o_conv_func_init}, 2'b00);
    kept();
    for (int i = 0; i < 300 && o_restart !== 1'b1; i++) step();
    check("restart", o_restart, 1);
    check("wake", o_state, RBR_WAKE);
    check("pd wake", o_power_down_flag, 1);
    check("start", {o_restart_page, o_restart_addr}, {START_PAGE, START_ADDR});
    step();
    check("run", o_state, RBR_RUN);
    kept();
    // program reinitialises the timer flags, whose value back-up leaves undefined
    flags(8'h00, 8'h07);
    check("pd clr", o_power_down_flag, 0);
    check("timers init", {o_timer_a_irq_flag, o_timer_b_irq_flag}, 2'b00);
    flags(8'h00, 8'h00);
    $display("test round %0d done", sv);
  endtask : round
  task automatic results();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      failures++;
      results();
    end
  end
  initial begin
    lf = 8'h4e;
    flags(8'h00, 8'h00);
    instr(4);
    repeat (6) @(posedge i_ref_clk);
    #10 i_nrst = 1;
    i_instr_valid = 0;
    check("sp rst", o_stack_level_pointer, SP_RST);
    check("wdog en", o_watchdog_enable_flag, 1);
    for (int i = 0; i < 14; i++) begin
      lf = lfsr(lf);
      exp_r[i] = lf[3:0];
      i_cfg_we = (i != 12);
      i_port_we = (i == 12);
      i_cfg_sel = (i == 13) ? 4'hf : i[3:0];
      i_cfg_wdata = lf[3:0];
      i_port_wdata = lf[3:0];
      step();
    end
    i_cfg_we = 0;
    i_port_we = 0;
    kept();
    $display("test cfg done");
    flags(8'hff, 8'hff);
    check("set wins", fl, 6'h3f);
    check("timers set", {o_timer_a_irq_flag, o_timer_b_irq_flag}, 2'b11);
    flags(8'h00, 8'hfe);
    check("clr", fl, 6'h02);
    check("timers clr", {o_timer_a_irq_flag, o_timer_b_irq_flag}, 2'b00);
    // enable instruction without the strap must not arm the detector
    i_has_voltage_drop = 0;
    instr(3);
    check("no strap", o_voltage_drop_active, 0);
    i_has_voltage_drop = 1;
    instr(1);
    instr(0);
    instr(2);
    instr(1);
    i_instr_valid = 0;
    check("noop", o_state, RBR_RUN);
    check("restart clr", fl, 6'h00);
    $display("test refusal done");
    round(0, lf);
    round(1, 8'h00);
    results();
  end
endmodule : test_rbr_ctrl
